/* test_uhp_hop_gen.sv */
/*
  Self-checking bench for the hopping generator: a table of frames, then
  idle refusal and a mid-run reset. Assumes the uhp_mod stand-in.
*/
`timescale 1ns/100ps
module test_uhp_hop_gen;
  import uhp_pkg::*;
  // Base spacings differ from defaults so a stuck default shows
  localparam logic [10:0] B1 = 11'h150;
  localparam logic [10:0] B2 = 11'h140;
  localparam logic [10:0] BL = 11'h044;
  typedef struct packed {
    logic [4:0] fl;
    logic [7:0] hdr;
    logic [7:0] pay;
    logic [3:0] pat;
  } uhp_row_s;
  // Flags: group two, attach, priority, low latency, repeat; pattern 0 = skip
  localparam uhp_row_s ROWS [20] = '{
    '{5'h10, 8'ha1, 8'h34, 4'h1}, '{5'h10, 8'h85, 8'h0f, 4'h2},
    '{5'h18, 8'h7f, 8'hff, 4'h6}, '{5'h10, 8'h00, 8'h00, 4'h3},
    '{5'h14, 8'hc3, 8'h5a, 4'h7}, '{5'h00, 8'h11, 8'h22, 4'h4},
    '{5'h02, 8'h99, 8'h66, 4'h1}, '{5'h10, 8'h42, 8'h24, 4'h1},
    '{5'h11, 8'h42, 8'h24, 4'h0}, '{5'h10, 8'h13, 8'h57, 4'h2},
    '{5'h10, 8'h24, 8'h68, 4'h3}, '{5'h10, 8'h35, 8'h79, 4'h4},
    '{5'h10, 8'h46, 8'h8a, 4'h5}, '{5'h10, 8'h57, 8'h9b, 4'h1},
    '{5'h10, 8'h68, 8'hac, 4'h2}, '{5'h10, 8'h79, 8'hbd, 4'h3},
    '{5'h10, 8'h8a, 8'hce, 4'h4}, '{5'h10, 8'h9b, 8'hdf, 4'h5},
    '{5'h10, 8'hac, 8'he0, 4'h6}, '{5'h10, 8'hbd, 8'hf1, 4'h1}};
  localparam logic [4:0] C0 [1:7] = '{5'h04, 5'h03, 5'h06, 5'h03, 5'h05, 5'h01, 5'h05};
  localparam logic [4:0] C23 [1:7] = '{5'h0e, 5'h0e, 5'h0f, 5'h08, 5'h0b, 5'h08, 5'h0f};
  localparam logic [10:0] T3 [1:7] = '{11'h221, 11'h173, 11'h19e, 11'h18c, 11'h28f,
    11'h172, 11'h189};
  localparam logic [4:0] LLC [24] = '{5'h01, 5'h05, 5'h04, 5'h03, 5'h02, 5'h11, 5'h15,
    5'h14, 5'h13, 5'h12, 5'h09, 5'h0d, 5'h0c, 5'h0b, 5'h0a, 5'h06, 5'h00, 5'h07,
    5'h16, 5'h10, 5'h17, 5'h0e, 5'h08, 5'h0f};

  logic clk, rst, frame_start, frame_done, group_two_sel, frame_attach;
  logic frame_priority, frame_low_latency, frame_repeat, burst_req;
  logic [7:0] header_crc, payload_crc;
  logic burst_valid_q, burst_ext_q, go, gap;
  logic [4:0] burst_index_q, burst_carrier_number_q;
  logic [10:0] burst_interval_time_q;
  logic [1:0] hop_group_q;
  logic [3:0] hop_pattern_q;
  logic [5:0] n_req;
  logic [15:0] prv [4];
  int miscompares = 0;
  int n_checks = 0;
  int cyc = 0;

  uhp_hop_gen #(.GROUP_ONE_BASE(B1), .GROUP_TWO_BASE(B2), .GROUP_LL_BASE(BL))
  uhp_hop_gen_i (.clk(clk), .rst(rst), .frame_start(frame_start),
    .frame_done(frame_done), .group_two_sel(group_two_sel), .frame_attach(frame_attach),
    .frame_priority(frame_priority), .frame_low_latency(frame_low_latency),
    .frame_repeat(frame_repeat), .header_crc(header_crc), .payload_crc(payload_crc),
    .burst_req(burst_req), .burst_valid_q(burst_valid_q), .burst_ext_q(burst_ext_q),
    .burst_index_q(burst_index_q), .burst_carrier_number_q(burst_carrier_number_q),
    .burst_interval_time_q(burst_interval_time_q), .hop_group_q(hop_group_q),
    .hop_pattern_q(hop_pattern_q));

  uhp_mod uhp_mod_i (.clk(clk), .rst(rst), .go(go), .gap(gap), .n_req(n_req),
    .burst_req(burst_req), .burst_valid_q(burst_valid_q), .burst_ext_q(burst_ext_q),
    .burst_index_q(burst_index_q), .burst_carrier_number_q(burst_carrier_number_q),
    .burst_interval_time_q(burst_interval_time_q));

  task automatic stop_test;
    if (miscompares == 0 && n_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic chk(input logic [15:0] s, input logic [15:0] e);
    n_checks++;
    if (s !== e) begin
      miscompares++;
      $display("[FAIL] %0t seen %h expected %h", $time, s, e);
    end
  endtask

  // Expected register step, kept apart from the design's own code
  function automatic logic [15:0] nxt(input logic [15:0] r);
    return r[0] ? ((r >> 1) ^ 16'hb4f3) : (r >> 1);
  endfunction

  function automatic logic [15:0] llt(input int s);
    case (s)
      0: return 16'h0000;
      10: return 16'h007b;
      15: return 16'h003c;
      18: return 16'h00c6;
      21: return 16'h00ff;
      default: return 16'h0042;
    endcase
  endfunction

  // One frame: 24 core bursts, 3 extension bursts, frame_done left raised
  task automatic run_frame(input uhp_row_s r, input logic gp);
    logic [15:0] rv;
    logic [10:0] bs;
    int w;
    @(negedge clk);
    frame_done = 1'b0;
    frame_start = 1'b1;
    {group_two_sel, frame_attach, frame_priority, frame_low_latency, frame_repeat} = r.fl;
    header_crc = r.hdr;
    payload_crc = r.pay;
    @(negedge clk);
    frame_start = 1'b0;
    go = 1'b1;
    gap = gp;
    if (r.pat != 4'h0) chk(hop_pattern_q, r.pat);
    chk(hop_group_q, r.fl[1] ? 2'h2 : {1'b0, r.fl[4]});
    bs = r.fl[1] ? BL : (r.fl[4] ? B2 : B1);
    @(negedge clk);
    go = 1'b0;
    w = 0;
    while (uhp_mod_i.n_ans != 6'd27 && w < 400) begin
      @(negedge clk);
      w++;
    end
    chk(uhp_mod_i.n_ans, 16'd27);
    for (int s = 0; s < 24; s++) begin
      chk({uhp_mod_i.cap_ext[s], uhp_mod_i.cap_idx[s]}, 16'(s));
      if (r.fl[1]) begin
        chk(uhp_mod_i.cap_car[s], LLC[s]);
        chk(uhp_mod_i.cap_tim[s], llt(s));
      end else if (r.fl[4]) begin
        if (s % 3 == 1) chk(uhp_mod_i.cap_tim[s], 16'h0175);
        if (s % 3 == 2) chk(uhp_mod_i.cap_tim[s], 16'h013f);
      end
    end
    if (!r.fl[1] && r.fl[4] && r.pat != 4'h0) begin
      chk(uhp_mod_i.cap_car[0], C0[r.pat]);
      chk(uhp_mod_i.cap_car[23], C23[r.pat]);
      chk(uhp_mod_i.cap_tim[3], T3[r.pat]);
    end
    rv = {1'b1, r.hdr[6:0], r.pay};
    for (int k = 1; k < 4; k++) begin
      rv = nxt(rv);
      chk({uhp_mod_i.cap_ext[23 + k], uhp_mod_i.cap_idx[23 + k]}, 16'h20 + 16'(k));
      chk(uhp_mod_i.cap_car[23 + k], (rv >> 8) % 25);
      chk(uhp_mod_i.cap_tim[23 + k], bs + rv[6:0]);
      if (r.fl[0]) chk({uhp_mod_i.cap_car[23 + k], uhp_mod_i.cap_tim[23 + k]}, prv[k]);
      prv[k] = {uhp_mod_i.cap_car[23 + k], uhp_mod_i.cap_tim[23 + k]};
    end
    @(negedge clk);
    frame_done = 1'b1;
  endtask

  // Free-running 200 MHz clock
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  // Hang guard, well above the roughly 1200 cycles the run needs
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      miscompares++;
      stop_test();
    end
  end

  // Main sequence
  initial begin
    rst = 1'b1;
    {frame_start, frame_done, group_two_sel, frame_attach, frame_priority} = 5'h00;
    {frame_low_latency, frame_repeat, go, gap} = 4'h0;
    header_crc = 8'h00;
    payload_crc = 8'h00;
    n_req = 6'd27;
    repeat (3) @(posedge clk);
    @(negedge clk);
    chk({burst_valid_q, burst_ext_q, burst_index_q, burst_carrier_number_q}, 16'h0);
    chk({hop_group_q, hop_pattern_q, burst_interval_time_q[9:0]}, 16'h0400);
    rst = 1'b0;
    for (int i = 0; i < 20; i++) run_frame(ROWS[i], i[0]);
    // Requests after frame_done must go unanswered
    @(negedge clk);
    frame_done = 1'b0;
    n_req = 6'd2;
    go = 1'b1;
    @(negedge clk);
    go = 1'b0;
    repeat (6) @(negedge clk);
    chk(uhp_mod_i.n_ans, 16'h0);
    // Asynchronous reset mid-cycle restores pattern one and burst index zero before any edge
    n_req = 6'd27;
    #1 rst = 1'b1;
    #1 chk({hop_pattern_q, burst_index_q}, 16'h0020);
    repeat (3) @(negedge clk);
    rst = 1'b0;
    run_frame('{5'h10, 8'h5a, 8'ha5, 4'h1}, 1'b0);
    stop_test();
  end
endmodule

/* uhp_hop_gen.sv */
/*
  Uplink burst hopping pattern generator, top level. For each group two,
  low-latency or extension burst it hands out a carrier number and an interval to the previous burst.
  Assumes the frame builder pulses frame_start with the frame flags and
  check bytes, then burst_req once per burst, then frame_done.
*/
`timescale 1ns/100ps
module uhp_hop_gen
  import uhp_pkg::*;
#(
  parameter logic [uhp_pkg::INTERVAL_W-1:0] GROUP_ONE_BASE = uhp_pkg::BASE_GRP_ONE,
  parameter logic [uhp_pkg::INTERVAL_W-1:0] GROUP_TWO_BASE = uhp_pkg::BASE_GRP_TWO,
  parameter logic [uhp_pkg::INTERVAL_W-1:0] GROUP_LL_BASE = uhp_pkg::BASE_GRP_LL
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Frame control from the frame builder
  input wire logic frame_start,
  input wire logic frame_done,
  input wire logic group_two_sel,
  input wire logic frame_attach,
  input wire logic frame_priority,
  input wire logic frame_low_latency,
  input wire logic frame_repeat,
  input wire logic [7:0] header_crc,
  input wire logic [7:0] payload_crc,
  // Burst request and answer towards the modulator
  input wire logic burst_req,
  output logic burst_valid_q,
  output logic burst_ext_q,
  output logic [uhp_pkg::BURST_IDX_W-1:0] burst_index_q,
  output logic [uhp_pkg::CARRIER_W-1:0] burst_carrier_number_q,
  output logic [uhp_pkg::INTERVAL_W-1:0] burst_interval_time_q,
  // Frame-wide selection, for the modulator's own group-one tables
  output logic [1:0] hop_group_q,
  output logic [uhp_pkg::PATTERN_W-1:0] hop_pattern_q
);

  uhp_state_e state_q;
  logic [SEQ_IDX_W-1:0] seq_q;
  logic special_q;
  logic repeat_q;
  logic [LFSR_W-1:0] seed_q;
  logic [LFSR_W-1:0] lfsr_value;
  logic [LFSR_W-1:0] lfsr_next;
  logic [LFSR_W-1:0] seed_d;
  logic [BURST_IDX_W-1:0] idx_q;
  logic [PATTERN_W-1:0] pattern_d;
  uhp_group_e group_d;
  logic [INTERVAL_W-1:0] base_spacing;
  logic core_req;
  logic ext_req;

  // Every check below runs on the system clock and sleeps through reset
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  // Pattern number for each entry of the cyclic order
  function automatic logic [PATTERN_W-1:0] seq_pattern(input logic [SEQ_IDX_W-1:0] i);
    case (i)
      4'h0, 4'h4, 4'h9: seq_pattern = 4'h1;
      4'h1, 4'h5, 4'ha: seq_pattern = 4'h2;
      4'h2, 4'h6, 4'hb: seq_pattern = 4'h3;
      4'h3, 4'h7, 4'hc: seq_pattern = 4'h4;
      4'h8, 4'hd: seq_pattern = 4'h5;
      4'he: seq_pattern = 4'h6;
      default: seq_pattern = PAT_FIRST;
    endcase
  endfunction

  // Group two carriers come in triples a, a+16, a+8; one 3-bit base a per triple
  function automatic logic [CARRIER_W-1:0] gt2_carrier(input logic [PATTERN_W-1:0] p,
                                                       input logic [BURST_IDX_W-1:0] s);
    logic [23:0] row;
    logic [2:0] base;
    logic [2:0] trip;
    logic [1:0] pos;
    row = '0;
    case (p)
      4'h1: row = {3'd6, 3'd2, 3'd7, 3'd1, 3'd5, 3'd3, 3'd0, 3'd4};
      4'h2: row = {3'd6, 3'd1, 3'd0, 3'd4, 3'd5, 3'd2, 3'd7, 3'd3};
      4'h3: row = {3'd7, 3'd2, 3'd5, 3'd3, 3'd4, 3'd1, 3'd0, 3'd6};
      4'h4: row = {3'd0, 3'd6, 3'd7, 3'd2, 3'd5, 3'd4, 3'd1, 3'd3};
      4'h5: row = {3'd3, 3'd4, 3'd1, 3'd7, 3'd6, 3'd0, 3'd2, 3'd5};
      4'h6: row = {3'd0, 3'd2, 3'd5, 3'd7, 3'd6, 3'd4, 3'd3, 3'd1};
      4'h7: row = {3'd7, 3'd6, 3'd0, 3'd3, 3'd4, 3'd2, 3'd1, 3'd5};
      4'h8: row = {3'd4, 3'd0, 3'd2, 3'd7, 3'd1, 3'd5, 3'd6, 3'd3};
      default: row = '0;
    endcase
    trip = 3'(s / 5'd3);
    pos = 2'(s % 5'd3);
    base = row[trip*3 +: 3];
    case (pos)
      2'd1: gt2_carrier = {2'b10, base};
      2'd2: gt2_carrier = {2'b01, base};
      default: gt2_carrier = {2'b00, base};
    endcase
  endfunction

  // Group two times: 373, 319, then the pattern's varying entry
  function automatic logic [INTERVAL_W-1:0] gt2_time(input logic [PATTERN_W-1:0] p,
                                                     input logic [BURST_IDX_W-1:0] s);
    logic [69:0] row;
    logic [2:0] k;
    row = '0;
    case (p)
      4'h1: row = {10'd398, 10'd436, 10'd578, 10'd454, 10'd349, 10'd443, 10'd545};
      4'h2: row = {10'd376, 10'd657, 10'd379, 10'd354, 10'd363, 10'd410, 10'd371};
      4'h3: row = {10'd409, 10'd467, 10'd428, 10'd540, 10'd433, 10'd502, 10'd414};
      4'h4: row = {10'd354, 10'd416, 10'd457, 10'd471, 10'd631, 10'd516, 10'd396};
      4'h5: row = {10'd560, 10'd342, 10'd415, 10'd400, 10'd367, 10'd416, 10'd655};
      4'h6: row = {10'd365, 10'd380, 10'd545, 10'd593, 10'd465, 10'd451, 10'd370};
      4'h7: row = {10'd546, 10'd503, 10'd620, 10'd353, 10'd344, 10'd374, 10'd393};
      4'h8: row = {10'd486, 10'd351, 10'd519, 10'd579, 10'd584, 10'd346, 10'd367};
      default: row = '0;
    endcase
    k = 3'(s / 5'd3 - 5'd1);
    case (2'(s % 5'd3))
      2'd1: gt2_time = GT2_FIRST_TIME;
      2'd2: gt2_time = GT2_SECOND_TIME;
      default: gt2_time = (s == '0) ? '0 : {1'b0, row[k*10 +: 10]};
    endcase
  endfunction

  // Low-latency group carriers, one fixed pattern
  function automatic logic [CARRIER_W-1:0] gt3_carrier(input logic [BURST_IDX_W-1:0] s);
    logic [119:0] row;
    row = {5'd15, 5'd8, 5'd14, 5'd23, 5'd16, 5'd22, 5'd7, 5'd0,
           5'd6, 5'd10, 5'd11, 5'd12, 5'd13, 5'd9, 5'd18, 5'd19,
           5'd20, 5'd21, 5'd17, 5'd2, 5'd3, 5'd4, 5'd5, 5'd1};
    gt3_carrier = row[s*5 +: 5];
  endfunction

  // Low-latency group times: a flat spacing, zero at burst 0, four exceptions
  function automatic logic [INTERVAL_W-1:0] gt3_time(input logic [BURST_IDX_W-1:0] s);
    case (s)
      5'h00: gt3_time = '0;
      GT3_IDX10: gt3_time = GT3_TIME_AT10;
      GT3_IDX15: gt3_time = GT3_TIME_AT15;
      GT3_IDX18: gt3_time = GT3_TIME_AT18;
      GT3_IDX21: gt3_time = GT3_TIME_AT21;
      default: gt3_time = GT3_TIME;
    endcase
  endfunction

  // Group and pattern of a new frame; low latency overrides the chosen group
  always_comb begin
    if (frame_low_latency) begin
      group_d = UHP_GRP_LOW_LATENCY;
      pattern_d = PAT_FIRST;
    end else begin
      group_d = group_two_sel ? UHP_GRP_TWO : UHP_GRP_ONE;
      if (frame_attach) begin
        pattern_d = PAT_ATTACH;
      end else if (frame_priority) begin
        pattern_d = PAT_PRIORITY;
      end else begin
        pattern_d = seq_pattern(seq_q);
      end
    end
  end

  // Seed: forced top bit, seven header check bits, eight payload check bits
  assign seed_d = {1'b1, header_crc[6:0], payload_crc[7:0]};

  assign core_req = burst_req && (state_q == UHP_ST_CORE);
  assign ext_req = burst_req && (state_q == UHP_ST_EXT);

  // Base spacing of the group the core frame was sent in
  always_comb begin
    case (hop_group_q)
      UHP_GRP_TWO: base_spacing = GROUP_TWO_BASE;
      UHP_GRP_LOW_LATENCY: base_spacing = GROUP_LL_BASE;
      default: base_spacing = GROUP_ONE_BASE;
    endcase
  end

  uhp_lfsr u_lfsr (
    .clk(clk),
    .rst(rst),
    .load(frame_start),
    .seed(seed_d),
    .step(ext_req),
    .value(lfsr_value),
    .next_value(lfsr_next)
  );

  // Frame state: idle, core bursts, then extension bursts until frame_done
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_q <= UHP_ST_IDLE;
    end else if (frame_start) begin
      state_q <= UHP_ST_CORE;
    end else if (frame_done) begin
      state_q <= UHP_ST_IDLE;
    end else if (core_req && idx_q == CORE_LAST) begin
      state_q <= UHP_ST_EXT;
    end
  end

  // Frame-wide latches; a repeat reloads the same seed so values repeat
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      hop_group_q <= UHP_GRP_ONE;
      hop_pattern_q <= PAT_FIRST;
      special_q <= 1'b0;
      repeat_q <= 1'b0;
      seed_q <= '0;
    end else if (frame_start) begin
      hop_group_q <= group_d;
      hop_pattern_q <= pattern_d;
      special_q <= frame_low_latency || frame_attach || frame_priority;
      repeat_q <= frame_repeat;
      seed_q <= seed_d;
    end
  end

  // Pattern order index; special and repeated frames leave it alone
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      seq_q <= '0;
    end else if (frame_done && state_q != UHP_ST_IDLE && !special_q && !repeat_q) begin
      seq_q <= (seq_q == SEQ_LAST) ? '0 : seq_q + 4'h1;
    end
  end

  // Burst counter: core index 0..23, extension numbering from 1
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      idx_q <= '0;
    end else if (frame_start) begin
      idx_q <= '0;
    end else if (core_req) begin
      idx_q <= (idx_q == CORE_LAST) ? 5'h01 : idx_q + 5'h01;
    end else if (ext_req && idx_q != '1) begin
      idx_q <= idx_q + 5'h01;
    end
  end

  // Answer one cycle after each core or extension request; extension uses the stepped value
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      burst_valid_q <= 1'b0;
      burst_ext_q <= 1'b0;
      burst_index_q <= '0;
      burst_carrier_number_q <= '0;
      burst_interval_time_q <= '0;
    end else begin
      burst_valid_q <= core_req || ext_req;
      if (core_req) begin
        burst_ext_q <= 1'b0;
        burst_index_q <= idx_q;
        case (hop_group_q)
          UHP_GRP_TWO: begin
            burst_carrier_number_q <= gt2_carrier(hop_pattern_q, idx_q);
            burst_interval_time_q <= gt2_time(hop_pattern_q, idx_q);
          end
          UHP_GRP_LOW_LATENCY: begin
            burst_carrier_number_q <= gt3_carrier(idx_q);
            burst_interval_time_q <= gt3_time(idx_q);
          end
          default: begin
            // Group one tables live in the modulator; it uses hop_pattern_q
            burst_carrier_number_q <= '0;
            burst_interval_time_q <= '0;
          end
        endcase
      end else if (ext_req) begin
        burst_ext_q <= 1'b1;
        burst_index_q <= idx_q;
        burst_carrier_number_q <=
          CARRIER_W'((lfsr_next >> CARRIER_SHIFT) % EXT_CARRIER_MOD);
        // First one spans last core pilot centre to first extension pilot centre
        burst_interval_time_q <=
          base_spacing + INTERVAL_W'(lfsr_next[TIME_MOD_W-1:0]);
      end
    end
  end

  // Checks
  sequence s_ext_answer;
    burst_valid_q && burst_ext_q;
  endsequence

  sequence s_last_core_then_ext;
    core_req && idx_q == CORE_LAST ##1 burst_req;
  endsequence

  a_no_reserved_pattern: assert property (hop_pattern_q != PAT_RESERVED)
    else $error("reserved pattern selected");
  a_attach_pattern_six: assert property (
    frame_start && frame_attach && !frame_low_latency |=> hop_pattern_q == PAT_ATTACH)
    else $error("attach frame not on pattern six");
  a_low_latency_group: assert property (
    frame_start |=> (hop_group_q == UHP_GRP_LOW_LATENCY) == $past(frame_low_latency))
    else $error("low-latency group mismatch");
  a_order_wraps: assert property (
    $changed(seq_q) && $past(seq_q) == SEQ_LAST |-> seq_q == '0)
    else $error("pattern order did not wrap");
  a_order_step_one: assert property ($changed(seq_q) && seq_q != '0 |-> seq_q == $past(seq_q) + 4'h1)
    else $error("pattern order skipped");
  a_special_holds_order: assert property (
    frame_done && special_q |=> $stable(seq_q))
    else $error("special frame advanced order");
  a_ext_time_value: assert property (
    s_ext_answer |-> burst_interval_time_q == base_spacing + INTERVAL_W'(lfsr_value[6:0]))
    else $error("extension time wrong");
  a_ext_carrier_value: assert property (
    s_ext_answer |-> burst_carrier_number_q == CARRIER_W'(lfsr_value[15:8] % 8'd25))
    else $error("extension carrier wrong");
  a_first_ext_stepped: assert property (
    s_last_core_then_ext |=> burst_ext_q && burst_index_q == 5'h01 && lfsr_value != seed_q)
    else $error("first extension used the seed");
  a_group_two_fixed: assert property (
    core_req && hop_group_q == UHP_GRP_TWO && idx_q == 5'h04 |=>
      burst_interval_time_q == 11'd373)
    else $error("group two fixed time wrong");
  a_ll_first_carrier: assert property (
    core_req && hop_group_q == UHP_GRP_LOW_LATENCY && idx_q == '0 |=>
      burst_carrier_number_q == 5'd1 ##0 burst_valid_q)
    else $error("low-latency carrier start wrong");

endmodule

/* uhp_lfsr.sv */
/*
  Sixteen-bit Galois hopping register with seed load and single step.
  Assumes the caller never asserts load and step together.
*/
`timescale 1ns/100ps
module uhp_lfsr
  import uhp_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Control
  input wire logic load,
  input wire logic [uhp_pkg::LFSR_W-1:0] seed,
  input wire logic step,
  // State
  output logic [uhp_pkg::LFSR_W-1:0] value,
  output logic [uhp_pkg::LFSR_W-1:0] next_value
);

  logic [LFSR_W-1:0] reg_q;

  // One Galois step: shift right, fold the mask in when a one falls out
  always_comb begin
    next_value = {1'b0, reg_q[LFSR_W-1:1]};
    if (reg_q[0]) begin
      next_value = next_value ^ LFSR_MASK;
    end
  end

  // The new value depends only on the old one, so replays repeat exactly
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      reg_q <= '0;
    end else if (load) begin
      reg_q <= seed;
    end else if (step) begin
      reg_q <= next_value;
    end
  end

  assign value = reg_q;

endmodule

/* uhp_mod.sv */
/*
  Stand-in for the burst modulator: asks the generator for bursts and
  records every answer. Assumes requests are taken on the rising edge.
*/
`timescale 1ns/100ps
module uhp_mod
  import uhp_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Command from the bench
  input wire logic go,
  input wire logic gap,
  input wire logic [5:0] n_req,
  // Generator side
  output logic burst_req,
  input wire logic burst_valid_q,
  input wire logic burst_ext_q,
  input wire logic [uhp_pkg::BURST_IDX_W-1:0] burst_index_q,
  input wire logic [uhp_pkg::CARRIER_W-1:0] burst_carrier_number_q,
  input wire logic [uhp_pkg::INTERVAL_W-1:0] burst_interval_time_q
);
  logic [5:0] n_ans;
  logic cap_ext [32];
  logic [BURST_IDX_W-1:0] cap_idx [32];
  logic [CARRIER_W-1:0] cap_car [32];
  logic [INTERVAL_W-1:0] cap_tim [32];

  // Requests change on the falling edge; gap mode leaves two idle cycles
  initial begin
    burst_req = 1'b0;
    forever begin
      @(posedge clk);
      if (go) begin
        repeat (n_req) begin
          @(negedge clk);
          burst_req = 1'b1;
          if (gap) begin
            @(negedge clk);
            burst_req = 1'b0;
            @(negedge clk);
          end
        end
        @(negedge clk);
        burst_req = 1'b0;
      end
    end
  end

  // Answers are sampled on the rising edge, before the next one lands
  always @(posedge clk) begin
    if (rst || go) begin
      n_ans <= 6'h00;
    end else if (burst_valid_q) begin
      cap_ext[n_ans[4:0]] <= burst_ext_q;
      cap_idx[n_ans[4:0]] <= burst_index_q;
      cap_car[n_ans[4:0]] <= burst_carrier_number_q;
      cap_tim[n_ans[4:0]] <= burst_interval_time_q;
      n_ans <= n_ans + 6'h01;
    end
  end
endmodule

/* uhp_pkg.sv */
/*
  Constants for the uplink burst hopping pattern generator: pattern-group
  codes, state codes, field widths, fixed inter-burst times and the hopping register.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package uhp_pkg;

  // Output and field widths
  localparam int unsigned CARRIER_W = 5;
  localparam int unsigned INTERVAL_W = 11;
  localparam int unsigned PATTERN_W = 4;
  localparam int unsigned BURST_IDX_W = 5;
  localparam int unsigned SEQ_IDX_W = 4;
  localparam int unsigned LFSR_W = 16;

  // Pattern groups
  typedef enum logic [1:0] {
    UHP_GRP_ONE = 2'b00,
    UHP_GRP_TWO = 2'b01,
    UHP_GRP_LOW_LATENCY = 2'b10
  } uhp_group_e;

  // Frame state
  typedef enum logic [1:0] {
    UHP_ST_IDLE = 2'b00,
    UHP_ST_CORE = 2'b01,
    UHP_ST_EXT = 2'b10
  } uhp_state_e;

  // Pattern numbers with a fixed purpose
  localparam logic [PATTERN_W-1:0] PAT_FIRST = 4'h1;
  localparam logic [PATTERN_W-1:0] PAT_ATTACH = 4'h6;
  localparam logic [PATTERN_W-1:0] PAT_PRIORITY = 4'h7;
  localparam logic [PATTERN_W-1:0] PAT_RESERVED = 4'h8;

  // Last index of the cyclic pattern order and of the core bursts
  localparam logic [SEQ_IDX_W-1:0] SEQ_LAST = 4'he;
  localparam logic [BURST_IDX_W-1:0] CORE_LAST = 5'h17;

  // Group two fixed inter-burst times on positions 1 and 2 of each triple
  localparam logic [INTERVAL_W-1:0] GT2_FIRST_TIME = 11'h175;
  localparam logic [INTERVAL_W-1:0] GT2_SECOND_TIME = 11'h13f;

  // Group three inter-burst times
  localparam logic [INTERVAL_W-1:0] GT3_TIME = 11'h042;
  localparam logic [INTERVAL_W-1:0] GT3_TIME_AT10 = 11'h07b;
  localparam logic [INTERVAL_W-1:0] GT3_TIME_AT15 = 11'h03c;
  localparam logic [INTERVAL_W-1:0] GT3_TIME_AT18 = 11'h0c6;
  localparam logic [INTERVAL_W-1:0] GT3_TIME_AT21 = 11'h0ff;
  localparam logic [BURST_IDX_W-1:0] GT3_IDX10 = 5'h0a;
  localparam logic [BURST_IDX_W-1:0] GT3_IDX15 = 5'h0f;
  localparam logic [BURST_IDX_W-1:0] GT3_IDX18 = 5'h12;
  localparam logic [BURST_IDX_W-1:0] GT3_IDX21 = 5'h15;

  // Hopping register: Galois mask, forced seed bit, extension derivation
  localparam logic [LFSR_W-1:0] LFSR_MASK = 16'hb4f3;
  localparam int unsigned SEED_TOP_BIT = 15;
  localparam int unsigned TIME_MOD_W = 7;
  localparam int unsigned CARRIER_SHIFT = 8;
  localparam logic [7:0] EXT_CARRIER_MOD = 8'h19;

  // Default base spacings, in uplink symbol periods
  localparam logic [INTERVAL_W-1:0] BASE_GRP_ONE = 11'h14a;
  localparam logic [INTERVAL_W-1:0] BASE_GRP_TWO = 11'h13f;
  localparam logic [INTERVAL_W-1:0] BASE_GRP_LL = 11'h042;

endpackage
